// ==== design/sfr_defs.svh ====
/*
  register offsets, field positions, reset values and framing constants
  of the serial fifo / interrupt / rts enhancement block.
  assumes: included by bare name from files under design/.
*/
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH

`define SFR_OFF_RXPAR 8'h00
`define SFR_OFF_MODE 8'h04
`define SFR_OFF_TXPAR 8'h08
`define SFR_OFF_EXT 8'h0C
`define SFR_OFF_MISC 8'h10
`define SFR_OFF_STATUS 8'h14
`define SFR_OFF_TXDATA 8'h18
`define SFR_OFF_RXDATA 8'h1C
`define SFR_OFF_IRQSTAT 8'h20
`define SFR_OFF_IRQMASK 8'h24

`define SFR_REG_RESET 8'h00
`define SFR_EXT_TXLVL 5
`define SFR_EXT_RXLVL 3
`define SFR_EXT_AUTORTS 2
`define SFR_TXP_TXEN 3
`define SFR_TXP_RTS 1
`define SFR_MISC_FOU 2
`define SFR_MODE_LO 4
`define SFR_MODE_HI 5
`define SFR_MODE_SDLC 2'h2
`define SFR_STAT_RCA 0
`define SFR_STAT_TBE 2
`define SFR_IRQ_TX 0
`define SFR_IRQ_RX 1
`define SFR_IRQ_RTS 2
`define SFR_FLAG 8'h7E
`define SFR_TX_DEPTH 4
`define SFR_RX_DEPTH 8
`define SFR_RX_HALF 4
`define SFR_RESP_OKAY 2'h0
`define SFR_RESP_SLVERR 2'h2

`endif

// ==== design/sfr_pkg.sv ====
/*
  types of the serial fifo / interrupt / rts enhancement block.
  assumes: compiled before the design modules.
*/
package sfr_pkg;
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_OPEN = 4'h2,
    TX_DATA = 4'h4,
    TX_CLOSE = 4'h8
  } sfr_tx_state_t;
endpackage : sfr_pkg

// ==== design/sfr_fifo.sv ====
/*
  first-word-fall-through fifo with occupancy count.
  assumes: push is ignored when full, pop when empty; one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module sfr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1,
  localparam int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] din_i,
  input wire logic pop_i,
  output logic [WIDTH-1:0] dout_o,
  output logic [CW-1:0] count_o,
  output logic full_o,
  output logic empty_o
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic do_push;
  logic do_pop;

  assign do_push = push_i && (count_reg != CW'(DEPTH));
  assign do_pop = pop_i && (count_reg != '0);
  assign dout_o = mem_reg[rd_ptr_reg];
  assign count_o = count_reg;
  assign full_o = (count_reg == CW'(DEPTH));
  assign empty_o = (count_reg == '0);

  always_ff @(posedge clk_i)
  begin
    if (do_push)
    begin
      mem_reg[wr_ptr_reg] <= din_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : sfr_fifo
`default_nettype wire

// ==== design/sfr_ctrl.sv ====
/*
  serial channel enhancement: register readback, fifo interrupt levels,
  sdlc framer with automatic request-to-send release, axi4-lite slave.
  assumes: transmit clock arrives asynchronously on a pin; received bytes
  arrive as one-cycle strobes on clk_i.
*/
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sfr_defs.svh"
module sfr_ctrl #(
  parameter int TX_DEPTH = `SFR_TX_DEPTH,
  parameter int RX_DEPTH = `SFR_RX_DEPTH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic transmit_clock_pin_i,
  output logic txd_o,
  output logic rts_n_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic irq_o
);
  localparam int TCW = $clog2(TX_DEPTH + 1);
  localparam int RCW = $clog2(RX_DEPTH + 1);

  // ****************************************
  // registers and bus handshakes
  // ****************************************
  logic [7:0] receive_parameter_reg, mode_parameter_reg, transmit_parameter_reg;
  logic [7:0] extension_control, misc_tx_rx_control_reg, irq_stat_reg, irq_mask_reg;
  logic wr_fire, rd_fire, wr_hit, rd_hit;
  logic [7:0] rd_mux;
  logic tx_full, tx_empty, rx_full, rx_empty, tx_pop, rx_pop, tx_push;
  logic [7:0] tx_dout, rx_dout;
  logic [TCW-1:0] tx_count;
  logic [RCW-1:0] rx_count;
  logic [7:0] primary_status_reg;

  assign wr_fire = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `SFR_RESP_OKAY;
    end
    else
    begin
      // both channels are taken together once both are offered
      s_axi_awready_o <= s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_awready_o
        && !s_axi_bvalid_o;
      s_axi_wready_o <= s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_awready_o
        && !s_axi_bvalid_o;
      if (wr_fire)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_hit ? `SFR_RESP_OKAY : `SFR_RESP_SLVERR;
      end
      else if (s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always_comb
  begin
    case (s_axi_awaddr_i)
      `SFR_OFF_RXPAR, `SFR_OFF_MODE, `SFR_OFF_TXPAR, `SFR_OFF_EXT, `SFR_OFF_MISC,
      `SFR_OFF_TXDATA, `SFR_OFF_IRQMASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      receive_parameter_reg <= `SFR_REG_RESET;
      mode_parameter_reg <= `SFR_REG_RESET;
      transmit_parameter_reg <= `SFR_REG_RESET;
      extension_control <= `SFR_REG_RESET;
      misc_tx_rx_control_reg <= `SFR_REG_RESET;
      irq_mask_reg <= `SFR_REG_RESET;
    end
    else if (wr_fire && s_axi_wstrb_i[0])
    begin
      case (s_axi_awaddr_i)
        `SFR_OFF_RXPAR: receive_parameter_reg <= s_axi_wdata_i[7:0];
        `SFR_OFF_MODE: mode_parameter_reg <= s_axi_wdata_i[7:0];
        `SFR_OFF_TXPAR: transmit_parameter_reg <= s_axi_wdata_i[7:0];
        `SFR_OFF_EXT: extension_control <= s_axi_wdata_i[7:0];
        `SFR_OFF_MISC: misc_tx_rx_control_reg <= s_axi_wdata_i[7:0];
        `SFR_OFF_IRQMASK: irq_mask_reg <= s_axi_wdata_i[7:0];
        default: ;
      endcase
    end
  end

  assign tx_push = wr_fire && s_axi_wstrb_i[0] && (s_axi_awaddr_i == `SFR_OFF_TXDATA);
  assign rx_pop = rd_fire && (s_axi_araddr_i == `SFR_OFF_RXDATA);

  always_comb
  begin
    primary_status_reg = 8'h00;
    primary_status_reg[`SFR_STAT_RCA] = !rx_empty;
    primary_status_reg[`SFR_STAT_TBE] = !tx_full;
    rd_hit = 1'b1;
    case (s_axi_araddr_i)
      `SFR_OFF_RXPAR: rd_mux = receive_parameter_reg;
      `SFR_OFF_MODE: rd_mux = mode_parameter_reg;
      `SFR_OFF_TXPAR: rd_mux = transmit_parameter_reg;
      `SFR_OFF_EXT: rd_mux = extension_control;
      `SFR_OFF_MISC: rd_mux = misc_tx_rx_control_reg;
      `SFR_OFF_STATUS: rd_mux = primary_status_reg;
      `SFR_OFF_RXDATA: rd_mux = rx_empty ? 8'h00 : rx_dout;
      `SFR_OFF_IRQSTAT: rd_mux = irq_stat_reg;
      `SFR_OFF_IRQMASK: rd_mux = irq_mask_reg;
      default:
      begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `SFR_RESP_OKAY;
    end
    else
    begin
      s_axi_arready_o <= s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o;
      if (rd_fire)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= {24'h00_0000, rd_mux};
        s_axi_rresp_o <= rd_hit ? `SFR_RESP_OKAY : `SFR_RESP_SLVERR;
      end
      else if (s_axi_rready_i)
      begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // fifos
  // ****************************************
  sfr_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .clk_i(clk_i), .reset_i(reset_i), .push_i(tx_push), .din_i(s_axi_wdata_i[7:0]),
    .pop_i(tx_pop), .dout_o(tx_dout), .count_o(tx_count), .full_o(tx_full),
    .empty_o(tx_empty));

  sfr_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .clk_i(clk_i), .reset_i(reset_i), .push_i(rx_valid_i), .din_i(rx_data_i),
    .pop_i(rx_pop), .dout_o(rx_dout), .count_o(rx_count), .full_o(rx_full),
    .empty_o(rx_empty));

  // ****************************************
  // sdlc framer on the transmit clock
  // ****************************************
  logic txc_s1_reg, txc_s2_reg, txc_s3_reg, tx_tick;
  sfr_pkg::sfr_tx_state_t tx_state_reg, tx_state_next;
  logic [7:0] tx_shift_reg, tx_byte;
  logic [2:0] bit_cnt_reg;
  logic tx_load, close_end;
  logic auto_en, rts_ctl, sdlc_mode, fou;

  assign auto_en = extension_control[`SFR_EXT_AUTORTS];
  assign rts_ctl = transmit_parameter_reg[`SFR_TXP_RTS];
  assign sdlc_mode = mode_parameter_reg[`SFR_MODE_HI:`SFR_MODE_LO] == `SFR_MODE_SDLC;
  assign fou = misc_tx_rx_control_reg[`SFR_MISC_FOU];

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      txc_s1_reg <= 1'b0;
      txc_s2_reg <= 1'b0;
      txc_s3_reg <= 1'b0;
    end
    else
    begin
      txc_s1_reg <= transmit_clock_pin_i;
      txc_s2_reg <= txc_s1_reg;
      txc_s3_reg <= txc_s2_reg;
    end
  end
  assign tx_tick = txc_s2_reg && !txc_s3_reg;

  always_comb
  begin
    tx_state_next = tx_state_reg;
    tx_load = 1'b0;
    tx_pop = 1'b0;
    tx_byte = `SFR_FLAG;
    close_end = 1'b0;
    // byte boundaries fall on the tick after the previous byte's last bit
    if (tx_tick && bit_cnt_reg == 3'h0)
    begin
      case (tx_state_reg)
        sfr_pkg::TX_IDLE:
        begin
          if (transmit_parameter_reg[`SFR_TXP_TXEN] && !tx_empty)
          begin
            tx_load = 1'b1;
            tx_state_next = sfr_pkg::TX_OPEN;
          end
        end
        sfr_pkg::TX_OPEN, sfr_pkg::TX_DATA, sfr_pkg::TX_CLOSE:
        begin
          tx_load = 1'b1;
          if (!tx_empty)
          begin
            tx_pop = 1'b1;
            tx_byte = tx_dout;
            tx_state_next = sfr_pkg::TX_DATA;
          end
          else if (tx_state_reg != sfr_pkg::TX_CLOSE || fou)
          begin
            tx_state_next = sfr_pkg::TX_CLOSE;
          end
          else
          begin
            tx_load = 1'b0;
            close_end = 1'b1;
            tx_state_next = sfr_pkg::TX_IDLE;
          end
        end
        default: tx_state_next = sfr_pkg::TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tx_state_reg <= sfr_pkg::TX_IDLE;
      tx_shift_reg <= 8'hFF;
      bit_cnt_reg <= 3'h0;
      txd_o <= 1'b1;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      if (tx_load)
      begin
        txd_o <= tx_byte[0];
        tx_shift_reg <= {1'b1, tx_byte[7:1]};
        bit_cnt_reg <= 3'h1;
      end
      else if (tx_tick && bit_cnt_reg != 3'h0)
      begin
        txd_o <= tx_shift_reg[0];
        tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
      else if (tx_tick)
      begin
        txd_o <= 1'b1;
      end
    end
  end

  // pin is low while request-to-send is asserted
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rts_n_o <= 1'b1;
    end
    else if (!auto_en || rts_ctl)
    begin
      rts_n_o <= !rts_ctl;
    end
    else if (close_end && sdlc_mode && !fou)
    begin
      rts_n_o <= 1'b1;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  logic tx_cond, tx_cond_d_reg, rx_ev;
  logic [7:0] irq_set;

  assign tx_cond = extension_control[`SFR_EXT_TXLVL] ? tx_empty : !tx_full;
  assign rx_ev = rx_valid_i && !rx_full && (!extension_control[`SFR_EXT_RXLVL]
    || (rx_count == RCW'(`SFR_RX_HALF - 1) && !rx_pop));

  always_comb
  begin
    irq_set = 8'h00;
    irq_set[`SFR_IRQ_TX] = tx_cond && !tx_cond_d_reg;
    irq_set[`SFR_IRQ_RX] = rx_ev;
    irq_set[`SFR_IRQ_RTS] = close_end && auto_en && !rts_ctl && sdlc_mode && !fou;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      tx_cond_d_reg <= 1'b1;
      irq_stat_reg <= 8'h00;
      irq_o <= 1'b0;
    end
    else
    begin
      tx_cond_d_reg <= tx_cond;
      // a new event wins over the clearing read
      if (rd_fire && s_axi_araddr_i == `SFR_OFF_IRQSTAT)
      begin
        irq_stat_reg <= irq_set;
      end
      else
      begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_readback_ext;
    wr_fire && s_axi_wstrb_i[0] && s_axi_awaddr_i == `SFR_OFF_EXT
      |=> extension_control == $past(s_axi_wdata_i[7:0]);
  endproperty
  a_readback_ext: assert property (p_readback_ext) else $error("ext write lost");
  property p_tx_entry;
    !extension_control[`SFR_EXT_TXLVL] && $rose(!tx_full) |=> irq_stat_reg[`SFR_IRQ_TX];
  endproperty
  a_tx_entry: assert property (p_tx_entry) else $error("tx entry irq missing");
  property p_tx_empty;
    $rose(irq_stat_reg[`SFR_IRQ_TX]) && $past(extension_control[`SFR_EXT_TXLVL])
      |-> $past(tx_empty);
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx irq before empty");
  property p_tx_depth;
    tx_full |-> tx_count == TCW'(TX_DEPTH);
  endproperty
  a_tx_depth: assert property (p_tx_depth) else $error("tx depth wrong");
  property p_status;
    rd_fire && s_axi_araddr_i == `SFR_OFF_STATUS |=> s_axi_rdata_o[`SFR_STAT_TBE]
      == $past(!tx_full) && s_axi_rdata_o[`SFR_STAT_RCA] == $past(!rx_empty);
  endproperty
  a_status: assert property (p_status) else $error("status bits wrong");
  property p_rx_each;
    !extension_control[`SFR_EXT_RXLVL] && rx_valid_i && !rx_full
      |=> irq_stat_reg[`SFR_IRQ_RX];
  endproperty
  a_rx_each: assert property (p_rx_each) else $error("rx char irq missing");
  property p_rx_half;
    $rose(irq_stat_reg[`SFR_IRQ_RX]) && $past(extension_control[`SFR_EXT_RXLVL])
      |-> rx_count == RCW'(`SFR_RX_HALF);
  endproperty
  a_rx_half: assert property (p_rx_half) else $error("rx half irq early");
  property p_rts_auto_only;
    $rose(rts_n_o) && $past(auto_en) && !$past(rts_ctl) |-> $past(close_end);
  endproperty
  a_rts_auto_only: assert property (p_rts_auto_only) else $error("rts rose off frame");
  property p_rts_release;
    close_end && auto_en && !rts_ctl && sdlc_mode && !fou |=> rts_n_o ##1 rts_n_o;
  endproperty
  a_rts_release: assert property (p_rts_release) else $error("rts not released");
  property p_close_tick;
    close_end |-> tx_tick && tx_state_reg == sfr_pkg::TX_CLOSE;
  endproperty
  a_close_tick: assert property (p_close_tick) else $error("close off tick");
  property p_rts_direct;
    (!auto_en || rts_ctl) ##1 (!auto_en || rts_ctl) |-> rts_n_o == !$past(rts_ctl);
  endproperty
  a_rts_direct: assert property (p_rts_direct) else $error("rts not direct");

  c_release: cover property (close_end && auto_en && !rts_ctl ##1 rts_n_o);
  c_rx_half: cover property (extension_control[`SFR_EXT_RXLVL] && rx_ev);
  c_tx_full: cover property (tx_full ##[1:1000] tx_empty);
  c_frame: cover property (tx_state_reg == sfr_pkg::TX_OPEN ##[1:1000] close_end);
endmodule : sfr_ctrl
`default_nettype wire

// ==== testbench/sfr_line_model.sv ====
/*
  far side of the serial channel: transmit clock source, line listener
  and received-byte source.
  assumes: the bench starts the transmit clock only around a frame.
*/
`timescale 1ns/10ps
`default_nettype none
module sfr_line_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic txd_i,
  input wire logic rts_n_i,
  output logic transmit_clock_pin_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o
);
  logic [7:0] shift_reg;
  logic [7:0] got [0:7];
  int bits;

  initial
  begin
    transmit_clock_pin_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    shift_reg = 8'h00;
    bits = 0;
  end

  // 64 ns period, parks low between frames
  always #32 if (run_i || transmit_clock_pin_o) transmit_clock_pin_o = ~transmit_clock_pin_o;

  // listens only while request-to-send is asserted (low), lsb first
  always @(negedge transmit_clock_pin_o)
  begin
    if (rts_n_i === 1'b0)
    begin
      shift_reg = {txd_i, shift_reg[7:1]};
      bits = bits + 1;
      if (bits % 8 == 0 && bits <= 64)
        got[bits / 8 - 1] = shift_reg;
    end
  end

  // one-cycle strobe; the data lines show the inverse afterwards
  task automatic send_rx(input logic [7:0] b);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= b;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~b;
  endtask : send_rx
endmodule : sfr_line_model
`default_nettype wire

// ==== testbench/tb_sfr_ctrl.sv ====
/*
  self-checking bench of the serial enhancement block over axi4-lite.
  assumes: sfr_pkg, sfr_ctrl and sfr_line_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sfr_defs.svh"
module tb_sfr_ctrl;
  localparam logic [7:0] TX_BUFFER_EMPTY_FLAG = 8'h01 << `SFR_STAT_TBE;
  localparam logic [7:0] RX_CHAR_AVAILABLE_FLAG = 8'h01 << `SFR_STAT_RCA;
  localparam logic [1:0] OK = `SFR_RESP_OKAY;
  localparam logic [1:0] ERR = `SFR_RESP_SLVERR;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, transmit_clock_pin, txd, rts_n, rxv, irq, run = 1'b0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] rxd;
  logic [7:0] offs [0:5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h24};
  int err_total = 0;
  int checks = 0;

  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  sfr_ctrl #(.TX_DEPTH(`SFR_TX_DEPTH), .RX_DEPTH(`SFR_RX_DEPTH)) i_dut (
    .clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .transmit_clock_pin_i(transmit_clock_pin),
    .txd_o(txd), .rts_n_o(rts_n), .rx_valid_i(rxv), .rx_data_i(rxd), .irq_o(irq));

  sfr_line_model i_line (
    .clk_i(clk_i), .run_i(run), .txd_i(txd), .rts_n_i(rts_n),
    .transmit_clock_pin_o(transmit_clock_pin), .rx_valid_o(rxv), .rx_data_o(rxd));

  // ***************************************************************
  // bus tasks and comparison
  // ***************************************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk_i); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge clk_i);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er,
    input string n);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk_i);
    chk(n, {24'h0, ed}, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'b0;
    @(posedge clk_i);
  endtask : rd

  task automatic wait_irq();
    do @(posedge clk_i); while (irq !== 1'b1);
  endtask : wait_irq

  task automatic report_and_stop();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #200000;
    err_total++;
    report_and_stop();
  end

  // ***************************************************************
  // test sequence
  // ***************************************************************
  initial
  begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    chk("txd idle", 32'h1, {31'h0, txd});
    chk("rts_n idle", 32'h1, {31'h0, rts_n});
    for (int i = 0; i < 6; i++)
      rd(offs[i], `SFR_REG_RESET, OK, "reset value");
    for (int i = 0; i < 6; i++)
      wr(offs[i], 8'h51 + 8'(i), OK);
    for (int i = 0; i < 6; i++)
      rd(offs[i], 8'h51 + 8'(i), OK, "readback");
    for (int i = 0; i < 6; i++)
      wr(offs[i], 8'h00, OK);
    wr(`SFR_OFF_STATUS, 8'hFF, ERR);
    rd(8'h28, 8'h00, ERR, "unmapped");
    // rts follows its control bit without the automatic release
    wr(`SFR_OFF_TXPAR, 8'h02, OK);
    chk("rts_n direct on", 32'h0, {31'h0, rts_n});
    wr(`SFR_OFF_TXPAR, 8'h00, OK);
    chk("rts_n direct off", 32'h1, {31'h0, rts_n});
    // receive, every character
    i_line.send_rx(8'hC1);
    repeat (3) @(posedge clk_i);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(`SFR_OFF_STATUS, RX_CHAR_AVAILABLE_FLAG | TX_BUFFER_EMPTY_FLAG, OK, "status rx");
    wr(`SFR_OFF_IRQMASK, 8'h07, OK);
    repeat (3) @(posedge clk_i);
    chk("irq rx each", 32'h1, {31'h0, irq});
    rd(`SFR_OFF_IRQSTAT, 8'h02, OK, "irqstat rx");
    rd(`SFR_OFF_RXDATA, 8'hC1, OK, "rx byte");
    chk("irq cleared", 32'h0, {31'h0, irq});
    // receive, half full, then overfill
    wr(`SFR_OFF_EXT, 8'h08, OK);
    for (int i = 0; i < 8; i++)
    begin
      i_line.send_rx(8'hD0 + 8'(i));
      repeat (3) @(posedge clk_i);
      if (i == 2)
        chk("irq rx below half", 32'h0, {31'h0, irq});
      if (i == 3)
        chk("irq rx half", 32'h1, {31'h0, irq});
    end
    i_line.send_rx(8'hEE);
    rd(`SFR_OFF_IRQSTAT, 8'h02, OK, "irqstat half");
    for (int i = 0; i < 8; i++)
      rd(`SFR_OFF_RXDATA, 8'hD0 + 8'(i), OK, "rx fifo");
    rd(`SFR_OFF_RXDATA, 8'h00, OK, "rx empty");
    rd(`SFR_OFF_STATUS, TX_BUFFER_EMPTY_FLAG, OK, "status idle");
    // transmit frame with automatic release
    wr(`SFR_OFF_MODE, 8'h20, OK);
    wr(`SFR_OFF_EXT, 8'h04, OK);
    for (int i = 0; i < 5; i++)
      wr(`SFR_OFF_TXDATA, 8'h31 + 8'(i), OK);
    rd(`SFR_OFF_STATUS, 8'h00, OK, "status tx full");
    wr(`SFR_OFF_TXPAR, 8'h0A, OK);
    chk("rts_n frame", 32'h0, {31'h0, rts_n});
    run <= 1'b1;
    wait_irq();
    chk("bytes at entry free", 32'h1, 32'(i_line.bits / 8));
    rd(`SFR_OFF_IRQSTAT, 8'h01, OK, "irqstat tx free");
    wr(`SFR_OFF_TXPAR, 8'h08, OK);
    wr(`SFR_OFF_EXT, 8'h24, OK);
    chk("rts_n held", 32'h0, {31'h0, rts_n});
    wait_irq();
    chk("bytes at empty", 32'h4, 32'(i_line.bits / 8));
    rd(`SFR_OFF_IRQSTAT, 8'h01, OK, "irqstat tx empty");
    do @(posedge clk_i); while (rts_n !== 1'b1);
    chk("bits at release", 32'd48, 32'(i_line.bits));
    chk("clock at release", 32'h1, {31'h0, transmit_clock_pin});
    run <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(`SFR_OFF_IRQSTAT, 8'h04, OK, "irqstat release");
    for (int i = 0; i < 6; i++)
      chk("line byte", (i == 0 || i == 5) ? {24'h0, `SFR_FLAG} : 32'h30 + 32'(i),
        {24'h0, i_line.got[i]});
    rd(`SFR_OFF_STATUS, TX_BUFFER_EMPTY_FLAG, OK, "status end");
    // flag-on-underrun keeps sending flags, so no automatic release
    wr(`SFR_OFF_MISC, 8'h04, OK);
    wr(`SFR_OFF_TXDATA, 8'h5A, OK);
    wr(`SFR_OFF_TXPAR, 8'h0A, OK);
    wr(`SFR_OFF_TXPAR, 8'h08, OK);
    run <= 1'b1;
    repeat (700) @(posedge clk_i);
    chk("rts_n under fou", 32'h0, {31'h0, rts_n});
    wr(`SFR_OFF_MISC, 8'h00, OK);
    do @(posedge clk_i); while (rts_n !== 1'b1);
    run <= 1'b0;
    rd(`SFR_OFF_IRQSTAT, 8'h05, OK, "irqstat fou end");
    report_and_stop();
  end
endmodule : tb_sfr_ctrl
`default_nettype wire
